// ---- bench/i2c_host_model.sv ----
/*
  Behavioural two-wire bus host.
  Assumes the bench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic ref_clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  localparam int half = 3;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick();
    repeat (half) @(posedge ref_clk);
  endtask
  task automatic start();
    tick();
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_drv <= 1'b1;
    tick();
  endtask
  // Eight bits then the ninth, sampled at the end of each high phase
  task automatic xfer(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic s);
    logic [8:0] o;
    logic [8:0] r;
    o = {d, last};
    for (int i = 8; i >= 0; i--) begin
      sda_drv <= o[i];
      tick();
      scl <= 1'b1;
      tick();
      r[i] = sda_wire;
      scl <= 1'b0;
      tick();
    end
    q = r[8:1];
    s = r[0];
  endtask
endmodule
`default_nettype wire

// ---- bench/rate_ctrl_props.sv ----
/*
  Port checker for the rate and power-state controller.
  Assumes a bus host whose scl phases last at least 3 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module rate_ctrl_props #(
  parameter int unsigned TAP_CYC = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic cell_valid,
  input wire rate_ctrl_pkg::axes_type cell_data,
  input wire logic meas_req,
  input wire logic [2:0] orient_raw,
  input wire logic [2:0] orient_out,
  input wire logic int_out
);
  import rate_ctrl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  int unsigned gap_q;
  logic seen_q;
  // First pulse after reset has no predecessor to measure from
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap_q <= 0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= meas_req ? 1 : gap_q + 1;
      seen_q <= seen_q | meas_req;
    end
  end
  meas_pulse_a: assert property (meas_req |=> !meas_req)
    else $error("tap request wider than one cycle");
  meas_gap_a: assert property (meas_req && seen_q |-> gap_q >= TAP_CYC)
    else $error("tap requests closer than the tap period");
  sda_drain_a: assert property (sda_out == 1'b0)
    else $error("data pin value not held low");
  ack_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  ack_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive unstable in clock high phase");
  ack_bound_a: assert property ($rose(sda_oe) |-> ##[1:200] !sda_oe)
    else $error("data drive held too long");
  orient_src_a: assert property ($changed(orient_out) |->
    orient_out == $past(orient_raw) || orient_out == $past(orient_raw, 2)
    || orient_out == 3'h0)
    else $error("orientation changed to a value never sampled");
  reset_idle_a: assert property ($rose(resetn) |->
    int_out && !sda_oe && !meas_req)
    else $error("outputs not idle after reset");
  cover property (meas_req);
  cover property ($rose(sda_oe));
  cover property ($changed(int_out));
endmodule
bind sample_rate_sleep_wake_ctrl rate_ctrl_props #(.TAP_CYC(TAP_CYC)) props (
  .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .cell_valid(cell_valid),
  .cell_data(cell_data), .meas_req(meas_req), .orient_raw(orient_raw),
  .orient_out(orient_out), .int_out(int_out));
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the rate and power-state controller.
  Assumes the host model in i2c_host_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rate_ctrl_pkg::*;
  localparam logic [6:0] dev_addr = 7'h2a;
  localparam int unsigned act_cyc [8] = '{200, 220, 240, 260, 280, 300,
    310, 320};
  localparam int unsigned wake_cyc [4] = '{200, 240, 280, 320};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cell_valid = 1'b0;
  axes_type cell_data = '0;
  logic [2:0] orient_raw = 3'h0;
  logic scl, sda_drv, sda_w, sda_out, sda_oe, meas_req, int_out;
  logic [2:0] orient_out;
  int err_count = 0;
  int total_checks = 0;
  int unsigned cyc = 0;
  always #2 ref_clk = ~ref_clk;
  // Released data line floats to the pull-up level
  assign sda_w = sda_drv & ~sda_oe;
  sample_rate_sleep_wake_ctrl #(.DEV_ADDR(dev_addr), .ACTIVE_CYC(act_cyc),
    .WAKE_CYC(wake_cyc), .TAP_CYC(5)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .cell_valid(cell_valid),
    .cell_data(cell_data), .meas_req(meas_req), .orient_raw(orient_raw),
    .orient_out(orient_out), .int_out(int_out));
  i2c_host_model host (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv),
    .sda_wire(sda_w));
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    cell_valid <= $urandom_range(3, 0) != 0;
    if (cyc == 100000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic int unsigned exp_period(int i);
    return i < 8 ? act_cyc[i] : wake_cyc[i - 8];
  endfunction
  function automatic logic in_win(int unsigned e, int unsigned lo,
      int unsigned hi);
    return e >= lo && e <= hi;
  endfunction
  task automatic hdr(input logic rw);
    logic [7:0] q;
    logic s;
    host.start();
    host.xfer({dev_addr, rw}, 1'b1, q, s);
    chk("addr_ack", 0, s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic s;
    hdr(1'b0);
    host.xfer(a, 1'b1, q, s);
    host.xfer(d, 1'b1, q, s);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic s;
    hdr(1'b0);
    host.xfer(a, 1'b1, q, s);
    host.stop();
    hdr(1'b1);
    host.xfer(8'hff, 1'b1, d, s);
    host.stop();
  endtask
  task automatic ping();
    hdr(1'b0);
    host.stop();
  endtask
  // Sampled at the falling edge, clear of the launching edge
  task automatic wait_lvl(input logic lvl, input int lim, output logic hit);
    int n;
    n = 0;
    while (int_out !== lvl && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    hit = int_out === lvl;
  endtask
  initial begin
    logic [7:0] v, q;
    int unsigned t0, t1, x, w;
    logic hit;
    void'($urandom(32'h20a2d620));
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(sample_rate_cfg_addr, v);
    chk("sr_reset", reg_reset, v);
    rd(8'h0c, v);
    chk("unmapped", 0, v);
    host.start();
    host.xfer({dev_addr ^ 7'h01, 1'b0}, 1'b1, q, hit);
    host.stop();
    chk("foreign_nack", 1, hit);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      wr(sample_rate_cfg_addr, v);
      rd(sample_rate_cfg_addr, q);
      chk("sr_rw", v, q);
    end
    wr(int_enable_addr, 8'h10);
    for (int i = 0; i < 12; i++) begin
      cell_data <= 18'($urandom);
      wr(sample_rate_cfg_addr, i < 8 ? 8'(i) : 8'((i - 8) * 8));
      wr(mode_cfg_addr, i < 8 ? 8'h01 : 8'h09);
      wait_lvl(1'b0, 20000, hit);
      t0 = cyc;
      ping();
      chk("int_release", 1, int_out);
      wait_lvl(1'b0, 20000, hit);
      t1 = cyc;
      chk("int_seen", 1, hit);
      chk("period", exp_period(i), t1 - t0);
      rd(x_axis_result_addr, v);
      chk("x_result", cell_data.g[0], v[5:0]);
      rd(rate_status_addr, v);
      chk("status", i < 8 ? 1 : 2, v);
      wr(mode_cfg_addr, 8'h00);
    end
    wr(mode_cfg_addr, 8'h80);
    chk("int_idle_hi", 0, int_out);
    wr(mode_cfg_addr, 8'h81);
    wait_lvl(1'b1, 20000, hit);
    chk("int_act_hi", 1, hit);
    ping();
    chk("int_rel_hi", 0, int_out);
    wr(mode_cfg_addr, 8'h00);
    // An update can land after this write's release; clear it first
    ping();
    chk("int_idle_lo", 1, int_out);
    wr(int_enable_addr, 8'h08);
    wr(sample_rate_cfg_addr, 8'h00);
    for (int i = 0; i < 3; i++) begin
      // Case 2 uses the divide-by-16 sleep tick
      x = (i + 1) * act_cyc[0] * (i == 2 ? 16 : 1);
      w = act_cyc[0] * (i == 2 ? 16 : 1);
      wr(sleep_count_addr, 8'(i));
      wr(mode_cfg_addr, i == 2 ? 8'h31 : 8'h11);
      t0 = cyc;
      wait_lvl(1'b0, 20000, hit);
      chk("sleep_time", 1, in_win(cyc - t0, x - w, x + 4));
      rd(rate_status_addr, v);
      chk("sleep_state", 2, v);
      wr(mode_cfg_addr, 8'h00);
    end
    wr(tap_detect_cfg_addr, 8'h0a);
    wr(int_enable_addr, 8'h04);
    for (int i = 0; i < 3; i++) begin
      cell_data <= '0;
      wr(sample_rate_cfg_addr, i == 2 ? 8'h01 : 8'h00);
      wr(mode_cfg_addr, 8'h01);
      repeat (400) @(posedge ref_clk);
      ping();
      cell_data.g[0] <= i == 1 ? 6'h02 : 6'h19;
      wait_lvl(1'b0, 200, hit);
      chk("tap", i == 0, hit);
      wr(mode_cfg_addr, 8'h00);
    end
    wr(int_enable_addr, 8'h00);
    for (int n = 0; n < 8; n += 3) begin
      orient_raw <= 3'h0;
      wr(sample_rate_cfg_addr, 8'(n * 32));
      wr(mode_cfg_addr, 8'h01);
      repeat ((n + 2) * act_cyc[0]) @(posedge ref_clk);
      v = 8'($urandom_range(7, 1));
      orient_raw <= v[2:0];
      t0 = cyc;
      for (int k = 0; k < 2000 && orient_out !== v[2:0]; k++) begin
        @(negedge ref_clk);
      end
      x = n * act_cyc[0];
      chk("debounce", 1, in_win(cyc - t0, x, x + act_cyc[0] + 4));
      chk("orient", v[2:0], orient_out);
      wr(mode_cfg_addr, 8'h00);
    end
    // Auto-wake only: an orientation change brings the block back to run
    wr(sample_rate_cfg_addr, 8'h00);
    wr(int_enable_addr, 8'h03);
    wr(mode_cfg_addr, 8'h09);
    rd(rate_status_addr, v);
    chk("wake_sleep", 2, v);
    orient_raw <= ~orient_out;
    wait_lvl(1'b0, 4 * wake_cyc[0], hit);
    chk("wake_int", 1, hit);
    rd(rate_status_addr, v);
    chk("wake_run", 1, v);
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- core/rate_ctrl_pkg.sv ----
/*
  Constants, register map and carrier types for the sample-rate and
  power-state controller of a three-axis acceleration readout.
  Assumes a 250 MHz core clock; the controller's parameters derive all cycle counts from it.
*/
package rate_ctrl_pkg;

  localparam int unsigned clk_mhz = 250;

  // Sample periods per active rate code, in microseconds
  localparam int unsigned active_period_us [8] = '{
    8360, 15625, 31250, 62500, 125000, 250000, 500000, 1000000};
  // Sample periods per wake rate code, in microseconds
  localparam int unsigned wake_period_us [4] = '{
    31250, 62500, 125000, 1000000};
  // Fast tap sampling and tap check period
  localparam int unsigned tap_period_us = 260;

  localparam logic [2:0] tap_plus_fastest_rate = 3'h0;
  localparam logic [2:0] rate_64_per_s = 3'h1;
  localparam logic [2:0] rate_32_per_s = 3'h2;
  localparam logic [2:0] rate_16_per_s = 3'h3;

  // Register offsets
  localparam logic [7:0] x_axis_result_addr = 8'h00;
  localparam logic [7:0] y_axis_result_addr = 8'h01;
  localparam logic [7:0] z_axis_result_addr = 8'h02;
  localparam logic [7:0] rate_status_addr = 8'h04;
  localparam logic [7:0] sleep_count_addr = 8'h05;
  localparam logic [7:0] int_enable_addr = 8'h06;
  localparam logic [7:0] mode_cfg_addr = 8'h07;
  localparam logic [7:0] sample_rate_cfg_addr = 8'h08;
  localparam logic [7:0] tap_detect_cfg_addr = 8'h09;

  localparam logic [7:0] reg_reset = 8'h00;
  localparam logic [3:0] prescale_last = 4'hf;
  localparam int unsigned avg_samples = 32;
  localparam int unsigned avg_shift = 5;
  localparam int unsigned slow_shift = 3;
  localparam int unsigned axis_bits = 6;

  typedef struct packed {
    logic [2:0] orientation_debounce_code;
    logic [1:0] wake_rate_code;
    logic [2:0] active_rate_code;
  } sample_rate_cfg_type;

  typedef struct packed {
    logic int_polarity_high_sel;
    logic push_pull_sel;
    logic sleep_prescale_sel;
    logic auto_sleep_en;
    logic auto_wake_en;
    logic test_sel;
    logic spare;
    logic active_sel;
  } mode_cfg_type;

  typedef struct packed {
    logic [2:0] spare;
    logic update_en;
    logic sleep_exit_en;
    logic tap_en;
    logic [1:0] orient_en;
  } int_enable_type;

  typedef struct packed {
    logic [2:0][axis_bits-1:0] g;
  } axes_type;

  typedef enum logic [2:0] {
    pw_standby = 3'b001,
    pw_run = 3'b010,
    pw_sleep = 3'b100
  } power_state_type;

  typedef enum logic [6:0] {
    bus_idle = 7'b0000001,
    bus_addr = 7'b0000010,
    bus_ack_addr = 7'b0000100,
    bus_write = 7'b0001000,
    bus_ack_write = 7'b0010000,
    bus_read = 7'b0100000,
    bus_ack_read = 7'b1000000
  } bus_state_type;

endpackage

// ---- core/sample_rate_sleep_wake_ctrl.sv ----
/*
  Sample-rate, auto-sleep/auto-wake and interrupt control behind a
  two-wire register port. Assumes scl/sda and the sensing-cell inputs
  are synchronous to ref_clk; the pad resolves sda from sda_oe.
*/
// What this block does
// - Interrupt level follows polarity select bit
// - Address acknowledge releases pending interrupt
// - Enable bits choose run, sleep or both
// - Interrupts work in every enable combination
// - Sleep timeout spans 1 to 256 ticks
// - Sample rate register at 0x08, reset zero
// - Code 000 enables tap filtering and detection
// - Fast running averages refresh on each valid cell sample in tap mode
// - Tap when filter difference exceeds threshold
// - Code 000 averages 32 samples per 8.36 ms
// - Code 001 gives 64 updates per second
// - Code 010 gives 32 updates per second
// - Code 011 gives 16 updates per second
// - Codes 100..111 give 8,4,2,1 updates
// - Wake codes give 32,16,8,1 updates
// - Debounce code N needs N+1 matches
// - Sleep counter clocked by rate, optionally /16
`timescale 1ns/1ps
`default_nettype none
module sample_rate_sleep_wake_ctrl
  import rate_ctrl_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary bus address
  parameter int unsigned ACTIVE_CYC [8] = '{
    active_period_us[0] * clk_mhz, active_period_us[1] * clk_mhz,
    active_period_us[2] * clk_mhz, active_period_us[3] * clk_mhz,
    active_period_us[4] * clk_mhz, active_period_us[5] * clk_mhz,
    active_period_us[6] * clk_mhz, active_period_us[7] * clk_mhz},
  parameter int unsigned WAKE_CYC [4] = '{
    wake_period_us[0] * clk_mhz, wake_period_us[1] * clk_mhz,
    wake_period_us[2] * clk_mhz, wake_period_us[3] * clk_mhz},
  parameter int unsigned TAP_CYC = tap_period_us * clk_mhz
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic cell_valid,
  input wire rate_ctrl_pkg::axes_type cell_data,
  output logic meas_req,
  input wire logic [2:0] orient_raw,
  output logic [2:0] orient_out,
  output logic int_out
);
  import rate_ctrl_pkg::*;

  bus_state_type bus_q;
  power_state_type pw_q;
  mode_cfg_type mode_q;
  sample_rate_cfg_type sr_q;
  int_enable_type int_en_q;
  logic [7:0] sleep_max_q, tap_thr_q, ptr_q, shift_q, tx_q, rd_data;
  logic [3:0] bit_cnt_q, pre_cnt_q;
  logic [7:0] sleep_cnt_q;
  logic [31:0] rate_cnt_q, fast_cnt_q, rate_period;
  logic scl_q, sda_q, rw_q, first_q, int_pend_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic addr_match_evt, wr_byte_evt, rd_load_evt;
  logic reg_wr, sleep_restart, axis_clear;
  logic rate_tick, fast_tick, sleep_tick, timeout, sleep_exit_evt;
  logic tap_mode, tap_evt, update_evt, orient_evt, wake_evt, any_evt;
  logic [5:0] avg_cnt_q;
  logic [2:0] tap_hit;
  logic [2:0] cand_q;
  logic [3:0] match_cnt_q, match_next;
  logic [axis_bits-1:0] result_q [3];

  // Two-wire slave: edges and bus conditions
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;
  assign addr_match_evt = (bus_q == bus_addr) && scl_fall &&
    (bit_cnt_q == 4'h8) && (shift_q[7:1] == DEV_ADDR);
  assign wr_byte_evt = (bus_q == bus_write) && scl_fall &&
    (bit_cnt_q == 4'h8);
  assign rd_load_evt = scl_fall && (((bus_q == bus_ack_addr) && rw_q) ||
    (bus_q == bus_ack_read));
  assign reg_wr = wr_byte_evt && !first_q;
  assign sda_out = 1'b0;
  assign sda_oe = (bus_q == bus_ack_addr) || (bus_q == bus_ack_write) ||
    ((bus_q == bus_read) && !tx_q[7]);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_q <= bus_idle;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'hff;
      rw_q <= 1'b0;
    end else if (start_cond) begin
      bus_q <= bus_addr;
      bit_cnt_q <= 4'h0;
    end else if (stop_cond) begin
      bus_q <= bus_idle;
    end else begin
      unique case (bus_q)
        bus_idle: begin
        end
        bus_addr, bus_write: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_in};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == 4'h8) begin
            if (bus_q == bus_write) begin
              bus_q <= bus_ack_write;
            end else if (addr_match_evt) begin
              bus_q <= bus_ack_addr;
              rw_q <= shift_q[0];
            end else begin
              bus_q <= bus_idle;
            end
          end
        end
        bus_ack_addr, bus_ack_write: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            bus_q <= (bus_q == bus_ack_addr && rw_q) ? bus_read : bus_write;
            tx_q <= rd_data;
          end
        end
        bus_read: begin
          if (scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              bus_q <= bus_ack_read;
              tx_q <= 8'hff;
            end else begin
              tx_q <= {tx_q[6:0], 1'b1};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        bus_ack_read: begin
          if (scl_rise && sda_in) begin
            bus_q <= bus_idle;
          end else if (scl_fall) begin
            bus_q <= bus_read;
            bit_cnt_q <= 4'h0;
            tx_q <= rd_data;
          end
        end
        default: bus_q <= bus_idle;
      endcase
    end
  end

  // Register pointer: first written byte sets it, each access bumps it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q <= 8'h00;
      first_q <= 1'b0;
    end else if (addr_match_evt) begin
      first_q <= ~shift_q[0];
    end else if (wr_byte_evt && first_q) begin
      ptr_q <= shift_q;
      first_q <= 1'b0;
    end else if (reg_wr || rd_load_evt) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  always_comb begin
    unique case (ptr_q)
      x_axis_result_addr: rd_data = {2'b00, result_q[0]};
      y_axis_result_addr: rd_data = {2'b00, result_q[1]};
      z_axis_result_addr: rd_data = {2'b00, result_q[2]};
      rate_status_addr: rd_data = {6'h00, pw_q == pw_sleep, pw_q == pw_run};
      sleep_count_addr: rd_data = sleep_max_q;
      int_enable_addr: rd_data = int_en_q;
      mode_cfg_addr: rd_data = mode_q;
      sample_rate_cfg_addr: rd_data = sr_q;
      tap_detect_cfg_addr: rd_data = tap_thr_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= reg_reset;
      sr_q <= reg_reset;
      sleep_max_q <= reg_reset;
      int_en_q <= reg_reset;
      tap_thr_q <= reg_reset;
    end else if (reg_wr) begin
      unique case (ptr_q)
        sleep_count_addr: sleep_max_q <= shift_q;
        int_enable_addr: int_en_q <= shift_q;
        mode_cfg_addr: mode_q <= shift_q;
        sample_rate_cfg_addr: sr_q <= shift_q;
        tap_detect_cfg_addr: tap_thr_q <= {3'h0, shift_q[4:0]};
        default: begin
        end
      endcase
    end
  end

  // Writing or reading mode, or writing the max count, restarts timing
  assign axis_clear = reg_wr && (ptr_q == mode_cfg_addr);
  assign sleep_restart = axis_clear ||
    (reg_wr && ptr_q == sleep_count_addr) ||
    (rd_load_evt && ptr_q == mode_cfg_addr);

  // Power state
  assign timeout = sleep_tick && (sleep_cnt_q == sleep_max_q);
  assign sleep_exit_evt = (pw_q == pw_run) && mode_q.auto_sleep_en &&
    timeout;
  assign wake_evt = tap_evt & int_en_q.tap_en |
    orient_evt & (|int_en_q.orient_en);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pw_q <= pw_standby;
    end else if (!mode_q.active_sel) begin
      pw_q <= pw_standby;
    end else begin
      unique case (pw_q)
        pw_standby: pw_q <= (mode_q.auto_wake_en && !mode_q.auto_sleep_en)
          ? pw_sleep : pw_run;
        pw_run: if (sleep_exit_evt) pw_q <= pw_sleep;
        pw_sleep: if (wake_evt) pw_q <= pw_run;
        default: pw_q <= pw_standby;
      endcase
    end
  end

  // Rate dividers; wake codes apply only while sleeping
  assign rate_period = (pw_q == pw_sleep) ?
    WAKE_CYC[sr_q.wake_rate_code] : ACTIVE_CYC[sr_q.active_rate_code];
  assign rate_tick = (pw_q != pw_standby) &&
    (rate_cnt_q == rate_period - 32'd1);
  assign fast_tick = (pw_q != pw_standby) && (fast_cnt_q == TAP_CYC - 1);
  assign tap_mode = (sr_q.active_rate_code == tap_plus_fastest_rate) &&
    (pw_q == pw_run);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rate_cnt_q <= 32'd0;
      fast_cnt_q <= 32'd0;
      meas_req <= 1'b0;
    end else begin
      rate_cnt_q <= (rate_tick || pw_q == pw_standby) ? 32'd0
        : rate_cnt_q + 32'd1;
      fast_cnt_q <= (fast_tick || pw_q == pw_standby) ? 32'd0
        : fast_cnt_q + 32'd1;
      meas_req <= fast_tick;
    end
  end

  // Sleep counter on the optionally /16 sample rate
  assign sleep_tick = (pw_q == pw_run) && rate_tick &&
    (!mode_q.sleep_prescale_sel || pre_cnt_q == prescale_last);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_q <= 4'h0;
      sleep_cnt_q <= 8'h00;
    end else if (sleep_restart || pw_q != pw_run || sleep_exit_evt) begin
      pre_cnt_q <= 4'h0;
      sleep_cnt_q <= 8'h00;
    end else begin
      if (rate_tick) pre_cnt_q <= pre_cnt_q + 4'h1;
      if (sleep_tick) sleep_cnt_q <= sleep_cnt_q + 8'h01;
    end
  end

  // Per-axis averaging and tap filter
  assign update_evt = rate_tick && (avg_cnt_q == 6'(avg_samples));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avg_cnt_q <= 6'h00;
    end else if (rate_tick || pw_q == pw_standby) begin
      avg_cnt_q <= 6'h00;
    end else if (cell_valid && avg_cnt_q != 6'(avg_samples)) begin
      avg_cnt_q <= avg_cnt_q + 6'h01;
    end
  end

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [10:0] sum_q;
    logic signed [7:0] prev_q, fast_q, slow_q, cur, diff;
    assign cur = 8'(signed'(cell_data.g[a]));
    assign diff = fast_q - slow_q;
    assign tap_hit[a] = tap_mode &&
      ((diff[7] ? -diff : diff) > signed'(tap_thr_q));
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        sum_q <= 11'sh000;
        result_q[a] <= 6'h00;
      end else if (axis_clear) begin
        sum_q <= 11'sh000;
        result_q[a] <= 6'h00;
      // Standby drops samples, so the first average after start holds 32
      end else if (rate_tick || pw_q == pw_standby) begin
        sum_q <= 11'sh000;
        if (update_evt) result_q[a] <= sum_q[10:avg_shift];
      end else if (cell_valid && avg_cnt_q != 6'(avg_samples)) begin
        sum_q <= sum_q + 11'(signed'(cell_data.g[a]));
      end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        prev_q <= 8'sh00;
        fast_q <= 8'sh00;
        slow_q <= 8'sh00;
      end else if (cell_valid && tap_mode) begin
        prev_q <= cur;
        fast_q <= (cur + prev_q) >>> 1;
        slow_q <= slow_q + ((fast_q - slow_q) >>> slow_shift);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tap_evt <= 1'b0;
    end else begin
      tap_evt <= fast_tick && (|tap_hit);
    end
  end

  // Orientation debounce at the sample rate
  assign match_next = (orient_raw == cand_q && match_cnt_q != 4'hf) ?
    match_cnt_q + 4'h1 : 4'h1;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cand_q <= 3'h0;
      match_cnt_q <= 4'h0;
      orient_out <= 3'h0;
      orient_evt <= 1'b0;
    end else begin
      orient_evt <= 1'b0;
      if (rate_tick) begin
        cand_q <= orient_raw;
        match_cnt_q <= match_next;
        if (match_next > {1'b0, sr_q.orientation_debounce_code} &&
            orient_raw != orient_out) begin
          orient_out <= orient_raw;
          orient_evt <= 1'b1;
        end
      end
    end
  end

  // Interrupt: any enabled event in any enable combination; set wins
  assign any_evt = (tap_evt & int_en_q.tap_en) |
    (orient_evt & (|int_en_q.orient_en)) |
    (sleep_exit_evt & int_en_q.sleep_exit_en) |
    (update_evt & int_en_q.update_en);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_pend_q <= 1'b0;
    end else if (any_evt) begin
      int_pend_q <= 1'b1;
    end else if (addr_match_evt) begin
      int_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_out <= 1'b1;
    end else begin
      int_out <= mode_q.int_polarity_high_sel ? int_pend_q
        : ~int_pend_q;
    end
  end

endmodule
`default_nettype wire
